// file: rtl/rtcas_scheduler.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
// Notes on behaviour
// - Kind selector 0x00 picks the basic scheduler, 0x01 the calendar scheduler.
// - Nothing is executed until the run control holds 0x01.
// - A slot with a nonzero activation stamp executes once running.
// - Start year, month and day are two-digit BCD values.
// - A sequence starts when the clock equals the programmed BCD date, hour, minute.
// - Each action stays on for the programmed duration in minutes.
// - Further actions start the repetition time after the previous action's start.
// - With a multiplier of one the repetition time is ignored.
// - A sequence holds as many actions as the multiplier says.
// - The sequence restarts every sequence repetition time in hours.
// - Host power flag set: action switches host on, then off after duration.
// - Relay flag set: action sets the relay, then resets it after duration.
// - Event stamp contents never affect execution.
// - All active slots run concurrently, each with its own timing.
// - Slot selector steers programming and reading to one slot; zero is first.
// - Mirror copies of the clock values are readable.
// - Slot selector accepts only 0 to 3 and resets to zero.
// - While running, every scheduler register except run refuses writes.
module rtcas_scheduler (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic minuteTickPin,
  input wire logic [7:0] rtcMinute,
  input wire logic [7:0] rtcHour,
  input wire logic [7:0] rtcMday,
  input wire logic [7:0] rtcMonth,
  input wire logic [7:0] rtcYear,
  output logic hostPowerOn,
  output logic relayOn,
  output logic relaySetPulse,
  output logic relayResetPulse,
  output logic basicSchedSelect
);
  import rtcas_pkg::*;

  logic [1:0] slotSel_reg;
  logic [7:0] run_reg, kind_reg;
  logic [7:0] slotMem [NUM_SLOTS][SLOT_FIELDS];
  logic [7:0] rdNext;
  logic runOn, engineEn, tick, wrWin, wrLocked;
  logic [NUM_SLOTS-1:0] slotOn, hostReq, relayReq;
  logic relayLast_reg;

  // Minute tick arrives from the oscillator domain
  rtcas_tick_sync u_tick (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .tickPin(minuteTickPin),
    .tickPulse(tick)
  );

  assign runOn = run_reg == VAL_ON;
  assign engineEn = runOn && kind_reg == KIND_CAL;
  assign wrWin = regWrEn && (regAddr & REG_WIN_MASK) == REG_SLOT_BASE;
  // Program lock: the running engine must never see fields move under it
  assign wrLocked = runOn;

  // Slot selector, only legal indices are taken
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      slotSel_reg <= RST_SLOT;
    end else if (regWrEn && regAddr == REG_SLOT_SEL && !wrLocked) begin
      if (regWrData < 8'(NUM_SLOTS)) slotSel_reg <= regWrData[1:0];
    end
  end

  // Run control, stays writable so the host can stop the engine
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_reg <= RST_BYTE;
    end else if (regWrEn && regAddr == REG_RUN) begin
      if (regWrData == VAL_ON || regWrData == VAL_OFF) run_reg <= regWrData;
    end
  end

  // Scheduler kind, two legal values
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      kind_reg <= KIND_BASIC;
    end else if (regWrEn && regAddr == REG_KIND && !wrLocked) begin
      if (regWrData == KIND_BASIC || regWrData == KIND_CAL) kind_reg <= regWrData;
    end
  end

  // Slot programming lands in the selected slot only
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int s = 0; s < NUM_SLOTS; s++) begin
        for (int f = 0; f < SLOT_FIELDS; f++) begin
          slotMem[s][f] <= RST_BYTE;
        end
      end
    end else if (wrWin && !wrLocked) begin
      slotMem[slotSel_reg][regAddr[3:0]] <= regWrData;
    end
  end

  // Independent engine per slot; event stamp bytes reach no engine, only the read decode
  for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
    rtcas_slot u_slot (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .enable(engineEn),
      .tick(tick),
      .active(slotMem[g][F_ACTIVE] != VAL_OFF),
      .startMin(slotMem[g][F_MINUTE]),
      .startHour(slotMem[g][F_HOUR]),
      .startMday(slotMem[g][F_MDAY]),
      .startMonth(slotMem[g][F_MONTH]),
      .startYear(slotMem[g][F_YEAR]),
      .rtcMinute(rtcMinute),
      .rtcHour(rtcHour),
      .rtcMday(rtcMday),
      .rtcMonth(rtcMonth),
      .rtcYear(rtcYear),
      .duration({slotMem[g][F_DUR_HI], slotMem[g][F_DUR_LO]}),
      .actRep(slotMem[g][F_ACT_REP]),
      .mult(slotMem[g][F_MULT]),
      .seqRep(slotMem[g][F_SEQ_REP]),
      .actOn(slotOn[g])
    );
    // Each slot steers only the outputs its flags enable
    assign hostReq[g] = slotOn[g] && slotMem[g][F_HOST] == VAL_ON;
    assign relayReq[g] = slotOn[g] && slotMem[g][F_RELAY] == VAL_ON;
  end

  // Outputs merge all slots; overlapping actions keep the output on
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hostPowerOn <= 1'b0;
      relayOn <= 1'b0;
    end else begin
      hostPowerOn <= |hostReq;
      relayOn <= |relayReq;
    end
  end

  // Bistable relay needs a coil pulse per change, not a level
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      relayLast_reg <= 1'b0;
      relaySetPulse <= 1'b0;
      relayResetPulse <= 1'b0;
    end else begin
      relayLast_reg <= relayOn;
      relaySetPulse <= relayOn && !relayLast_reg;
      relayResetPulse <= !relayOn && relayLast_reg;
    end
  end

  // Basic scheduler lives elsewhere; it is told when it owns the clock
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) basicSchedSelect <= 1'b1;
    else basicSchedSelect <= kind_reg == KIND_BASIC;
  end

  // Read decode; unmapped addresses read zero
  always_comb begin
    rdNext = 8'h00;
    if ((regAddr & REG_WIN_MASK) == REG_SLOT_BASE) begin
      rdNext = slotMem[slotSel_reg][regAddr[3:0]];
    end else begin
      unique case (regAddr)
        REG_SLOT_SEL: rdNext = {6'h00, slotSel_reg};
        REG_RUN: rdNext = run_reg;
        REG_KIND: rdNext = kind_reg;
        REG_MIR_MIN: rdNext = rtcMinute;
        REG_MIR_HOUR: rdNext = rtcHour;
        REG_MIR_MDAY: rdNext = rtcMday;
        REG_MIR_MONTH: rdNext = rtcMonth;
        REG_MIR_YEAR: rdNext = rtcYear;
        REG_STATUS: begin
          rdNext[ST_HOST] = hostPowerOn;
          rdNext[ST_RELAY] = relayOn;
          rdNext[ST_SLOT0 +: NUM_SLOTS] = slotOn;
        end
        default: rdNext = 8'h00;
      endcase
    end
  end

  // Read data stands for exactly one cycle after the strobe
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) regRdData <= 8'h00;
    else if (regRdEn) regRdData <= rdNext;
    else regRdData <= 8'h00;
  end

  a_kind_gates_out: assert property (@(posedge sys_clk) disable iff (!arst_n)
    kind_reg != KIND_CAL ##1 kind_reg != KIND_CAL |=> !hostPowerOn && !relayOn)
    else $error("outputs active under basic scheduler");
  a_run_gates_out: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !runOn ##1 !runOn |=> !hostPowerOn && !relayOn && slotOn == '0)
    else $error("action while not running");
  a_host_follow: assert property (@(posedge sys_clk) disable iff (!arst_n)
    |hostReq |=> hostPowerOn)
    else $error("host power not following slot");
  a_relay_pulse: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(relayOn) |=> relaySetPulse ##1 !relaySetPulse)
    else $error("relay set pulse missing");
  a_sel_range: assert property (@(posedge sys_clk) disable iff (!arst_n)
    regWrEn && regAddr == REG_SLOT_SEL && regWrData > 8'h03 |=> $stable(slotSel_reg))
    else $error("illegal slot index taken");
  a_run_lock: assert property (@(posedge sys_clk) disable iff (!arst_n)
    runOn && regWrEn && (regAddr == REG_KIND || regAddr == REG_SLOT_SEL) |=> $stable(kind_reg) && $stable(slotSel_reg))
    else $error("register changed while running");
  a_lock_slot: assert property (@(posedge sys_clk) disable iff (!arst_n)
    runOn && wrWin && regAddr[3:0] == F_DUR_LO |=> $stable(slotMem[slotSel_reg][F_DUR_LO]))
    else $error("slot field changed while running");
  a_sel_read: assert property (@(posedge sys_clk) disable iff (!arst_n)
    regRdEn && regAddr == REG_SLOT_SEL |=> regRdData == {6'h00, slotSel_reg})
    else $error("slot selector read mismatch");
  a_mirror_read: assert property (@(posedge sys_clk) disable iff (!arst_n)
    regRdEn && regAddr == REG_MIR_HOUR |=> regRdData == $past(rtcHour))
    else $error("mirror read mismatch");
  a_read_once: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !regRdEn |=> regRdData == 8'h00)
    else $error("read data held too long");

  // Run takes the two legal values and ignores the rest
  a_run_take: assert property (@(posedge sys_clk) disable iff (!arst_n)
    regWrEn && regAddr == REG_RUN && (regWrData == VAL_ON || regWrData == VAL_OFF) |=> run_reg == $past(regWrData))
    else $error("run write not taken");

  a_run_refuse: assert property (@(posedge sys_clk) disable iff (!arst_n)
    regWrEn && regAddr == REG_RUN && regWrData != VAL_ON && regWrData != VAL_OFF |=> $stable(run_reg))
    else $error("illegal run value taken");

  // Kind is only written while stopped, and only with a legal code
  a_kind_take: assert property (@(posedge sys_clk) disable iff (!arst_n)
    regWrEn && regAddr == REG_KIND && !runOn && (regWrData == KIND_BASIC || regWrData == KIND_CAL)
    |=> kind_reg == $past(regWrData))
    else $error("kind write not taken");

  a_kind_refuse: assert property (@(posedge sys_clk) disable iff (!arst_n)
    regWrEn && regAddr == REG_KIND && regWrData != KIND_BASIC && regWrData != KIND_CAL |=> $stable(kind_reg))
    else $error("illegal kind value taken");

  // The basic scheduler flag mirrors the kind one cycle later
  a_basic_flag: assert property (@(posedge sys_clk) disable iff (!arst_n)
    kind_reg == KIND_BASIC |=> basicSchedSelect)
    else $error("basic scheduler not selected");

  a_cal_flag: assert property (@(posedge sys_clk) disable iff (!arst_n)
    kind_reg != KIND_BASIC |=> !basicSchedSelect)
    else $error("basic scheduler still selected");

  // A stopped engine clears every slot at once
  a_stop_clears: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !engineEn |=> slotOn == '0)
    else $error("slot action survived stop");

  // Between ticks a running engine never moves its actions
  a_tick_only: assert property (@(posedge sys_clk) disable iff (!arst_n)
    engineEn && !tick |=> $stable(slotOn))
    else $error("slot action moved without a tick");

  // Outputs drop as soon as no slot asks for them
  a_host_drop: assert property (@(posedge sys_clk) disable iff (!arst_n)
    hostReq == '0 |=> !hostPowerOn)
    else $error("host power without a request");

  a_relay_follow: assert property (@(posedge sys_clk) disable iff (!arst_n)
    |relayReq |=> relayOn)
    else $error("relay not following slot");

  a_relay_drop: assert property (@(posedge sys_clk) disable iff (!arst_n)
    relayReq == '0 |=> !relayOn)
    else $error("relay without a request");

  // The reset coil gets exactly one pulse per release
  a_relay_clear: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $fell(relayOn) |=> relayResetPulse ##1 !relayResetPulse)
    else $error("relay reset pulse missing");

  // Selector writes land only when legal and stopped
  a_sel_take: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !runOn && regWrEn && regAddr == REG_SLOT_SEL && regWrData < 8'(NUM_SLOTS)
    |=> {6'h00, slotSel_reg} == $past(regWrData))
    else $error("legal slot index not taken");

  // Window writes reach the selected slot and no other
  a_slot_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !runOn && wrWin && slotSel_reg == RST_SLOT && regAddr[3:0] == F_DUR_LO
    |=> slotMem[0][F_DUR_LO] == $past(regWrData))
    else $error("slot write lost");

  a_slot_other: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !runOn && wrWin && slotSel_reg != RST_SLOT && regAddr[3:0] == F_DUR_LO
    |=> $stable(slotMem[0][F_DUR_LO]))
    else $error("write reached an unselected slot");

  // Reads return what stood in the strobe cycle
  a_win_read: assert property (@(posedge sys_clk) disable iff (!arst_n)
    regRdEn && (regAddr & REG_WIN_MASK) == REG_SLOT_BASE && slotSel_reg == RST_SLOT && regAddr[3:0] == F_DUR_LO
    |=> regRdData == $past(slotMem[0][F_DUR_LO]))
    else $error("slot window read mismatch");

  a_status_read: assert property (@(posedge sys_clk) disable iff (!arst_n)
    regRdEn && regAddr == REG_STATUS |=> regRdData == {2'h0, $past(slotOn), $past(relayOn), $past(hostPowerOn)})
    else $error("status read mismatch");

  a_run_read: assert property (@(posedge sys_clk) disable iff (!arst_n)
    regRdEn && regAddr == REG_RUN |=> regRdData == $past(run_reg))
    else $error("run read mismatch");

  a_kind_read: assert property (@(posedge sys_clk) disable iff (!arst_n)
    regRdEn && regAddr == REG_KIND |=> regRdData == $past(kind_reg))
    else $error("kind read mismatch");
endmodule

// file: rtl/rtcas_pkg.sv
package rtcas_pkg;
  localparam int NUM_SLOTS = 4;
  localparam int SLOT_FIELDS = 16;
  // Register map
  localparam logic [7:0] REG_SLOT_SEL = 8'h16;
  localparam logic [7:0] REG_RUN = 8'h17;
  localparam logic [7:0] REG_KIND = 8'h19;
  localparam logic [7:0] REG_SLOT_BASE = 8'h20;
  localparam logic [7:0] REG_WIN_MASK = 8'hf0;
  localparam logic [7:0] REG_MIR_MIN = 8'h30;
  localparam logic [7:0] REG_MIR_HOUR = 8'h31;
  localparam logic [7:0] REG_MIR_MDAY = 8'h32;
  localparam logic [7:0] REG_MIR_MONTH = 8'h33;
  localparam logic [7:0] REG_MIR_YEAR = 8'h34;
  localparam logic [7:0] REG_STATUS = 8'h35;
  // Field index inside a slot window; 13..15 hold event stamps
  localparam logic [3:0] F_ACTIVE = 4'h0;
  localparam logic [3:0] F_MINUTE = 4'h1;
  localparam logic [3:0] F_HOUR = 4'h2;
  localparam logic [3:0] F_MDAY = 4'h3;
  localparam logic [3:0] F_MONTH = 4'h4;
  localparam logic [3:0] F_YEAR = 4'h5;
  localparam logic [3:0] F_DUR_LO = 4'h6;
  localparam logic [3:0] F_DUR_HI = 4'h7;
  localparam logic [3:0] F_ACT_REP = 4'h8;
  localparam logic [3:0] F_MULT = 4'h9;
  localparam logic [3:0] F_SEQ_REP = 4'ha;
  localparam logic [3:0] F_HOST = 4'hb;
  localparam logic [3:0] F_RELAY = 4'hc;
  // Values and reset values
  localparam logic [7:0] VAL_OFF = 8'h00;
  localparam logic [7:0] VAL_ON = 8'h01;
  localparam logic [7:0] KIND_BASIC = 8'h00;
  localparam logic [7:0] KIND_CAL = 8'h01;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_SLOT = 2'h0;
  // Status bit positions
  localparam int ST_HOST = 0;
  localparam int ST_RELAY = 1;
  localparam int ST_SLOT0 = 2;
  localparam logic [15:0] MIN_PER_HOUR = 16'h003c;
endpackage

// file: rtl/rtcas_tick_sync.sv
`timescale 1ns/1ns
module rtcas_tick_sync (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic tickPin,
  output logic tickPulse
);
  logic meta_reg, sync_reg, last_reg;

  // Two-stage synchroniser, then rising-edge detect on the clean copy
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= tickPin;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign tickPulse = sync_reg & ~last_reg;
endmodule

// file: rtl/rtcas_slot.sv
`timescale 1ns/1ns
module rtcas_slot (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic enable,
  input wire logic tick,
  input wire logic active,
  input wire logic [7:0] startMin,
  input wire logic [7:0] startHour,
  input wire logic [7:0] startMday,
  input wire logic [7:0] startMonth,
  input wire logic [7:0] startYear,
  input wire logic [7:0] rtcMinute,
  input wire logic [7:0] rtcHour,
  input wire logic [7:0] rtcMday,
  input wire logic [7:0] rtcMonth,
  input wire logic [7:0] rtcYear,
  input wire logic [15:0] duration,
  input wire logic [7:0] actRep,
  input wire logic [7:0] mult,
  input wire logic [7:0] seqRep,
  output logic actOn
);
  import rtcas_pkg::*;
  typedef enum {SLOT_WAIT, SLOT_SEQ} rtcas_slot_state_e;
  rtcas_slot_state_e state_reg;
  logic [15:0] seqCnt_reg, durLeft_reg, seqLen;
  logic [7:0] repCnt_reg, acts_reg;
  logic dateMatch, seqWrap, repDue, startSeq, startAct;

  // BCD fields compared digit for digit, no conversion needed
  assign dateMatch = rtcYear == startYear && rtcMonth == startMonth && rtcMday == startMday
    && rtcHour == startHour && rtcMinute == startMin;
  assign seqLen = 16'({8'h00, seqRep} * MIN_PER_HOUR);
  assign seqWrap = seqRep != VAL_OFF && 16'(seqCnt_reg + 16'h0001) == seqLen;
  // A single-action sequence never looks at the spacing
  assign repDue = mult != VAL_ON && acts_reg < mult && 8'(repCnt_reg + 8'h01) == actRep;
  assign startSeq = tick && enable && active
    && ((state_reg == SLOT_WAIT && dateMatch) || (state_reg == SLOT_SEQ && seqWrap));
  assign startAct = startSeq || (tick && enable && state_reg == SLOT_SEQ && repDue);

  // Waits for the start stamp, then cycles sequences until run drops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) state_reg <= SLOT_WAIT;
    else if (!enable) state_reg <= SLOT_WAIT;
    else if (startSeq) state_reg <= SLOT_SEQ;
  end

  // Minutes since the sequence began; saturates when never repeated
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) seqCnt_reg <= 16'h0000;
    else if (startSeq) seqCnt_reg <= 16'h0000;
    else if (tick && state_reg == SLOT_SEQ && seqCnt_reg != 16'hffff) seqCnt_reg <= 16'(seqCnt_reg + 16'h0001);
  end

  // Spacing counts from the previous start, not its end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      repCnt_reg <= 8'h00;
      acts_reg <= 8'h00;
    end else if (startSeq) begin
      repCnt_reg <= 8'h00;
      acts_reg <= 8'h01;
    end else if (startAct) begin
      repCnt_reg <= 8'h00;
      acts_reg <= 8'(acts_reg + 8'h01);
    end else if (tick && state_reg == SLOT_SEQ && repCnt_reg != 8'hff) begin
      repCnt_reg <= 8'(repCnt_reg + 8'h01);
    end
  end

  // Action held for the duration in minutes; a restart reloads it
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      actOn <= 1'b0;
      durLeft_reg <= 16'h0000;
    end else if (!enable) begin
      actOn <= 1'b0;
      durLeft_reg <= 16'h0000;
    end else if (startAct) begin
      actOn <= duration != 16'h0000 && mult != VAL_OFF;
      durLeft_reg <= duration;
    end else if (tick && actOn) begin
      if (durLeft_reg <= 16'h0001) actOn <= 1'b0;
      durLeft_reg <= durLeft_reg - 16'h0001;
    end
  end

  a_start_on_match: assert property (@(posedge sys_clk) disable iff (!arst_n)
    tick && enable && active && state_reg == SLOT_WAIT && dateMatch && duration != 16'h0000 && mult != VAL_OFF
    |=> actOn && seqCnt_reg == 16'h0000 && state_reg == SLOT_SEQ)
    else $error("slot did not start on matching time");
  a_duration_end: assert property (@(posedge sys_clk) disable iff (!arst_n)
    enable && tick && actOn && durLeft_reg == 16'h0001 && !startAct |=> !actOn)
    else $error("action outlived its duration");
  a_mult_bound: assert property (@(posedge sys_clk) disable iff (!arst_n)
    state_reg == SLOT_SEQ && mult != VAL_OFF |-> acts_reg <= mult)
    else $error("more actions than multiplier");
  a_seq_restart: assert property (@(posedge sys_clk) disable iff (!arst_n)
    tick && enable && active && state_reg == SLOT_SEQ && seqWrap |=> seqCnt_reg == 16'h0000 && acts_reg == 8'h01)
    else $error("sequence did not restart");
endmodule

// file: verification/rtcas_host_model.sv
`timescale 1ns/1ns
// Host software side of the register port: strobes change just after a rising edge
module rtcas_host_model (
  input wire logic sys_clk,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrEn,
  output logic regRdEn,
  input wire logic [7:0] regRdData
);
  import rtcas_pkg::*;
  // Idle bus parked off the map so a stray strobe would touch nothing
  initial begin
    regAddr = 8'hff;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end
  // One-cycle write strobe with address and data beside it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe, taken once settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    @(negedge sys_clk);
    d = regRdData;
  endtask
  // Run is stopped first, otherwise the locked slot window would drop the writes
  task automatic progSlot(input logic [1:0] s, input logic [7:0] f [13]);
    wr(REG_RUN, VAL_OFF);
    wr(REG_SLOT_SEL, {6'h00, s});
    for (int i = 0; i < 13; i++) begin
      wr(REG_SLOT_BASE + 8'(i), f[i]);
    end
    // Purely time based schedule: event stamps left cleared
    for (int i = 13; i < SLOT_FIELDS; i++) begin
      wr(REG_SLOT_BASE + 8'(i), VAL_OFF);
    end
  endtask
endmodule

// file: verification/rtcas_scheduler_test.sv
`timescale 1ns/1ns
// Programs two schedules, walks the clock minute by minute and checks the action outputs
module rtcas_scheduler_test;
  import rtcas_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] regAddr, regWrData, regRdData;
  logic regWrEn, regRdEn;
  logic minuteTickPin = 1'b0;
  logic [7:0] rtcMinute = 8'h00, rtcHour = 8'h00, rtcMday = 8'h20, rtcMonth = 8'h08, rtcYear = 8'h17;
  logic hostPowerOn, relayOn, relaySetPulse, relayResetPulse, basicSchedSelect;
  int fails = 0;
  int cmpCount = 0;
  int setCnt = 0;
  int clrCnt = 0;
  logic [7:0] slotA [13];
  logic [7:0] slotB [13];

  always #5 sys_clk = ~sys_clk;

  rtcas_host_model host (.sys_clk(sys_clk), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData));

  rtcas_scheduler DUT (.sys_clk(sys_clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .minuteTickPin(minuteTickPin),
    .rtcMinute(rtcMinute), .rtcHour(rtcHour), .rtcMday(rtcMday), .rtcMonth(rtcMonth), .rtcYear(rtcYear),
    .hostPowerOn(hostPowerOn), .relayOn(relayOn), .relaySetPulse(relaySetPulse),
    .relayResetPulse(relayResetPulse), .basicSchedSelect(basicSchedSelect));

  // Count relay coil pulses; a stuck pulse would inflate the count
  always @(posedge sys_clk) begin
    if (relaySetPulse === 1'b1) setCnt++;
    if (relayResetPulse === 1'b1) clrCnt++;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    cmpCount++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp, input string msg);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, exp, msg);
  endtask

  // Clock fields set with the tick edge; the synchroniser delay leaves them stable long enough
  task automatic tick(input logic [7:0] h, input logic [7:0] m);
    @(posedge sys_clk);
    rtcHour <= h;
    rtcMinute <= m;
    minuteTickPin <= 1'b1;
    repeat (3) @(posedge sys_clk);
    minuteTickPin <= 1'b0;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  function automatic logic [7:0] bcd(input int v);
    return 8'(((v / 10) << 4) | (v % 10));
  endfunction

  task automatic finishTest;
    $display("Counts: %0d compares, %0d mismatches", cmpCount, fails);
    if (fails == 0 && cmpCount > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog: the tests need fewer than a thousand cycles
  initial begin
    #500000;
    fails++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    finishTest();
  end

  // Main sequence
  initial begin
    int t;
    logic hExp;
    logic rExp;
    slotA = '{8'h01, 8'h59, 8'h09, 8'h20, 8'h08, 8'h17, 8'h03, 8'h00, 8'h00, 8'h01, 8'h18, 8'h00, 8'h01};
    slotB = '{8'h01, 8'h00, 8'h10, 8'h20, 8'h08, 8'h17, 8'h01, 8'h00, 8'h02, 8'h03, 8'h01, 8'h01, 8'h00};
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    chk({7'h00, basicSchedSelect}, 8'h01, "basic after reset");
    rdChk(REG_SLOT_SEL, RST_BYTE, "slot select reset");
    rdChk(REG_RUN, VAL_OFF, "run reset");
    rdChk(REG_KIND, KIND_BASIC, "kind reset");
    host.wr(REG_RUN, 8'h02);
    rdChk(REG_RUN, VAL_OFF, "run 2 refused");
    host.wr(REG_KIND, 8'h02);
    rdChk(REG_KIND, KIND_BASIC, "kind 2 refused");
    rdChk(8'h50, 8'h00, "unmapped read");
    host.wr(REG_SLOT_SEL, 8'h04);
    rdChk(REG_SLOT_SEL, 8'h00, "slot 4 refused");
    $display("test reset done");
    host.progSlot(2'h0, slotA);
    host.progSlot(2'h1, slotB);
    // Spoiled event stamp must not change slot 1 timing
    host.wr(REG_SLOT_BASE + 8'h0d, 8'h5a);
    rdChk(REG_SLOT_BASE + 8'h08, 8'h02, "slot 1 repetition");
    host.wr(REG_SLOT_SEL, 8'h00);
    rdChk(REG_SLOT_BASE + 8'h06, 8'h03, "slot 0 duration");
    host.wr(REG_KIND, KIND_CAL);
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk({7'h00, basicSchedSelect}, 8'h00, "calendar selected");
    // Start minute passes while stopped: nothing may switch
    tick(8'h09, 8'h59);
    chk({7'h00, relayOn}, 8'h00, "relay while stopped");
    rdChk(REG_MIR_HOUR, 8'h09, "mirror hour");
    host.wr(REG_RUN, VAL_ON);
    host.wr(REG_SLOT_BASE + 8'h06, 8'h09);
    host.wr(REG_SLOT_SEL, 8'h02);
    rdChk(REG_SLOT_SEL, 8'h00, "select locked");
    rdChk(REG_SLOT_BASE + 8'h06, 8'h03, "duration locked");
    rdChk(REG_MIR_YEAR, 8'h17, "mirror year");
    // Walk 09:58 to 11:02; slot 1 restarts after one hour
    for (int i = -2; i <= 62; i++) begin
      t = 600 + i;
      tick(bcd(t / 60), bcd(t % 60));
      hExp = (i >= 0) && ((i % 60) inside {0, 2, 4});
      rExp = (i >= -1) && (i <= 1);
      chk({7'h00, hostPowerOn}, {7'h00, hExp}, "host power");
      chk({7'h00, relayOn}, {7'h00, rExp}, "relay");
      if (i == 0) rdChk(REG_STATUS, 8'h0f, "both slots on");
    end
    chk(8'(setCnt), 8'h01, "relay set pulses");
    chk(8'(clrCnt), 8'h01, "relay reset pulses");
    // Stopping the scheduler drops every action
    host.wr(REG_RUN, VAL_OFF);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({7'h00, hostPowerOn}, 8'h00, "host off after stop");
    $display("test schedule done");
    finishTest();
  end
endmodule
